// *** core/posq_pkg.sv ***
// Purpose: Shared constants and types of the power-on init sequencer
// Assumes: 10 MHz system clock
// Notes: Stage dwell counts are small defaults; real durations are unknown
package posq_pkg;
  typedef enum {
    POSQ_OFF,
    POSQ_MEM_RESET,
    POSQ_CFG_LOAD,
    POSQ_IN_PINS,
    POSQ_LUTS,
    POSQ_SEQ_CELLS,
    POSQ_COMPLETE,
    POSQ_OUT_PINS,
    POSQ_RUN
  } posq_state_e;

  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned DWELL_W = 16;
  localparam logic [15:0] DWELL_MEM_RESET = 16'h0004;
  localparam logic [15:0] DWELL_CFG_LOAD = 16'h0010;
  localparam logic [15:0] DWELL_IN_PINS = 16'h0004;
  localparam logic [15:0] DWELL_LUTS = 16'h0004;
  localparam logic [15:0] DWELL_SEQ_CELLS = 16'h0004;
  localparam logic [15:0] DWELL_COMPLETE = 16'h0002;
  // Early reference drive window, in ns
  localparam int unsigned VREF_LEAD_MIN_NS = 3000;
  localparam int unsigned VREF_LEAD_MAX_NS = 5000;
  localparam int unsigned VREF_LEAD_CYC = (VREF_LEAD_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  // Low-power reference settle time, in us
  localparam int unsigned REF_SETTLE_US = 2000;
  localparam int unsigned REF_SETTLE_CYC = REF_SETTLE_US * (CLK_HZ / 1_000_000);
  localparam int unsigned REF_CNT_W = 16;
endpackage

// *** core/posq_dwell_if.sv ***
// Purpose: Carries a stage dwell request and its completion
// Assumes: One clock domain
// Notes: Start is a one-cycle pulse
`timescale 1ns/1ps
interface posq_dwell_if;
  logic start;
  logic [15:0] length;
  logic done;
  modport seq (output start, output length, input done);
  modport timer (input start, input length, output done);
endinterface

// *** core/posq_dwell_timer.sv ***
// Purpose: Counts down one stage dwell
// Assumes: Length of at least one cycle
// Notes: Done is a level while idle after expiry
`timescale 1ns/1ps
module posq_dwell_timer (
  input wire logic sys_clk,
  input wire logic nrst,
  posq_dwell_if.timer dw
);
  logic [15:0] count;
  logic running;
  logic fired;
  wire expire = running && (count == 16'h0001);

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      count <= 16'h0000;
      running <= 1'b0;
      fired <= 1'b0;
    end else if (dw.start) begin
      count <= dw.length;
      running <= 1'b1;
      fired <= 1'b0;
    end else if (running) begin
      count <= count - 16'h0001;
      running <= !expire;
      fired <= expire;
    end
  end

  // Held after expiry so a stage that also waits on an input cannot stall
  assign dw.done = expire || fired;
endmodule

// *** core/posq_sequencer.sv ***
// Purpose: Power-on init sequencer for a programmable mixed-signal device
// Assumes: power_on_threshold is an analog comparator level from outside
// Notes: Supply loss restarts the whole sequence from the first stage
`timescale 1ns/1ps
module posq_sequencer (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic power_on_threshold,
  input wire logic cfg_load_done,
  input wire logic ref_off_req,
  input wire logic ref_in_use,
  output logic mem_reset,
  output logic cfg_load,
  output logic macro_reset,
  output logic in_pins_en,
  output logic luts_en,
  output logic seq_cells_en,
  output logic slow_oscillator_en,
  output logic fast_oscillator_en,
  output logic seq_complete,
  output logic out_pins_oe,
  output logic vref_pin_oe,
  output logic low_power_reference_en,
  output logic low_power_reference_ready
);
  import posq_pkg::*;

  posq_state_e state;
  posq_state_e next_state;
  logic thr_meta;
  logic thr_sync;
  logic ld_meta;
  logic ld_sync;
  logic ref_off_meta;
  logic ref_off_sync;
  logic [REF_CNT_W-1:0] ref_cnt;
  logic [15:0] lead_cnt;

  posq_dwell_if dw ();
  posq_dwell_timer u_timer (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .dw(dw.timer)
  );

  // Pin level inputs come from outside the clock domain
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      thr_meta <= 1'b0;
      thr_sync <= 1'b0;
      ld_meta <= 1'b0;
      ld_sync <= 1'b0;
      ref_off_meta <= 1'b0;
      ref_off_sync <= 1'b0;
    end else begin
      thr_meta <= power_on_threshold;
      thr_sync <= thr_meta;
      ld_meta <= cfg_load_done;
      ld_sync <= ld_meta;
      ref_off_meta <= ref_off_req;
      ref_off_sync <= ref_off_meta;
    end
  end

  // Stage advances when its dwell expires; load also waits for the memory
  wire stage_done = dw.done;
  wire load_ok = stage_done && ld_sync;
  wire supply_lost = !thr_sync;

  always_comb begin
    next_state = state;
    if (supply_lost) begin
      next_state = POSQ_OFF;
    end else begin
      case (state)
        POSQ_OFF: next_state = POSQ_MEM_RESET;
        POSQ_MEM_RESET: if (stage_done) next_state = POSQ_CFG_LOAD;
        POSQ_CFG_LOAD: if (load_ok) next_state = POSQ_IN_PINS;
        POSQ_IN_PINS: if (stage_done) next_state = POSQ_LUTS;
        POSQ_LUTS: if (stage_done) next_state = POSQ_SEQ_CELLS;
        POSQ_SEQ_CELLS: if (stage_done) next_state = POSQ_COMPLETE;
        POSQ_COMPLETE: if (stage_done) next_state = POSQ_OUT_PINS;
        POSQ_OUT_PINS: next_state = POSQ_RUN;
        default: next_state = POSQ_RUN;
      endcase
    end
  end

  wire entering = (next_state != state);
  assign dw.start = entering;
  assign dw.length = (next_state == POSQ_MEM_RESET) ? DWELL_MEM_RESET :
                     (next_state == POSQ_CFG_LOAD) ? DWELL_CFG_LOAD :
                     (next_state == POSQ_IN_PINS) ? DWELL_IN_PINS :
                     (next_state == POSQ_LUTS) ? DWELL_LUTS :
                     (next_state == POSQ_SEQ_CELLS) ? DWELL_SEQ_CELLS :
                     DWELL_COMPLETE;

  // Stage outputs decoded from the next state so outputs stay registered
  wire n_mem_reset = (next_state == POSQ_MEM_RESET);
  wire n_cfg_load = (next_state == POSQ_CFG_LOAD);
  wire n_past_load = (next_state == POSQ_IN_PINS) || (next_state == POSQ_LUTS) ||
                     (next_state == POSQ_SEQ_CELLS) || (next_state == POSQ_COMPLETE) ||
                     (next_state == POSQ_OUT_PINS) || (next_state == POSQ_RUN);
  wire n_past_in = n_past_load && (next_state != POSQ_IN_PINS);
  wire n_past_lut = n_past_in && (next_state != POSQ_LUTS);
  wire n_past_seq = n_past_lut && (next_state != POSQ_SEQ_CELLS);
  wire n_out = (next_state == POSQ_OUT_PINS) || (next_state == POSQ_RUN);
  wire n_running = (next_state == POSQ_RUN);

  // Input pins enable at the end of their stage, after reset hold
  wire n_in_en = n_past_in;
  wire n_lut_en = n_past_lut;
  wire n_seq_en = n_past_seq;
  wire n_complete = n_out;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state <= POSQ_OFF;
      mem_reset <= 1'b0;
      cfg_load <= 1'b0;
      macro_reset <= 1'b1;
      in_pins_en <= 1'b0;
      luts_en <= 1'b0;
      seq_cells_en <= 1'b0;
      seq_complete <= 1'b0;
      out_pins_oe <= 1'b0;
    end else begin
      state <= next_state;
      mem_reset <= n_mem_reset;
      cfg_load <= n_cfg_load;
      macro_reset <= !n_past_load;
      in_pins_en <= n_in_en;
      luts_en <= n_lut_en;
      seq_cells_en <= n_seq_en;
      seq_complete <= n_complete;
      out_pins_oe <= n_running;
    end
  end

  // Slow oscillator starts at the end of the sequential cell stage, with seq_cells_en; fast also waits for reference ready
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      slow_oscillator_en <= 1'b0;
      fast_oscillator_en <= 1'b0;
    end else begin
      slow_oscillator_en <= n_seq_en;
      fast_oscillator_en <= n_seq_en && low_power_reference_ready;
    end
  end

  // Reference pin may lead completion by a short window
  wire lead_open = (state == POSQ_COMPLETE) && (lead_cnt >= 16'(VREF_LEAD_CYC));
  // Count kept through the completion stage so the pin enable cannot pulse
  wire lead_count = (state == POSQ_SEQ_CELLS) && !supply_lost;
  wire lead_hold = (state == POSQ_COMPLETE) && !supply_lost;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      lead_cnt <= 16'h0000;
      vref_pin_oe <= 1'b0;
    end else begin
      lead_cnt <= lead_count ? lead_cnt + 16'h0001 : (lead_hold ? lead_cnt : 16'h0000);
      vref_pin_oe <= !supply_lost && (lead_open || n_out);
    end
  end

  // Keeping reference on avoids a long settle; off only when unused or on supply loss
  wire ref_want = thr_sync && !(ref_off_sync && !ref_in_use);
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      low_power_reference_en <= 1'b0;
      low_power_reference_ready <= 1'b0;
      ref_cnt <= '0;
    end else begin
      low_power_reference_en <= ref_want;
      if (!ref_want) begin
        ref_cnt <= '0;
        low_power_reference_ready <= 1'b0;
      end else if (ref_cnt != REF_CNT_W'(REF_SETTLE_CYC)) begin
        ref_cnt <= ref_cnt + REF_CNT_W'(1);
      end else begin
        low_power_reference_ready <= 1'b1;
      end
    end
  end

  seq_order_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    $rose(luts_en) |-> in_pins_en) else $error("LUTs released before inputs");
  seq_cells_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    $rose(seq_cells_en) |-> luts_en) else $error("Cells before LUTs");
  complete_low_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    seq_complete |-> seq_cells_en) else $error("Completion too early");
  out_last_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    $rose(out_pins_oe) |-> $past(seq_complete)) else $error("Outputs before completion");
  pins_hiz_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    !thr_sync |=> !out_pins_oe) else $error("Pins driven while off");
  load_reset_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    cfg_load |-> macro_reset && !in_pins_en) else $error("Released during load");
  mem_first_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    $rose(cfg_load) |-> $past(mem_reset)) else $error("Load without memory reset");
  lut_low_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    mem_reset |-> !luts_en && !in_pins_en && !seq_cells_en) else $error("Outputs not low");
  slow_osc_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    seq_cells_en && !low_power_reference_en |-> slow_oscillator_en)
    else $error("Slow oscillator tied to reference");
endmodule

// *** testbench/posq_mem_model.sv ***
// Purpose: Configuration memory stand-in that answers a load request
// Assumes: Load request is a level held until the load finishes
// Notes: Done drops as soon as the request is withdrawn
`timescale 1ns/1ps
module posq_mem_model #(
  parameter int LOAD_CYC = 8
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic cfg_load,
  output logic cfg_load_done
);
  int cnt;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cnt <= 0;
      cfg_load_done <= 1'b0;
    end else if (!cfg_load) begin
      cnt <= 0;
      cfg_load_done <= 1'b0;
    end else if (cnt < LOAD_CYC) begin
      cnt <= cnt + 1;
    end else begin
      cfg_load_done <= 1'b1;
    end
  end
endmodule

// *** testbench/test_power_on_init_sequencer.sv ***
// Purpose: Self-checking bench for the power-on init sequencer
// Assumes: Package dwell constants as shipped
// Notes: Reference settle wait is the longest part of the run
`timescale 1ns/1ps
module test_power_on_init_sequencer;
  import posq_pkg::*;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic power_on_threshold = 1'b0;
  logic ref_off_req = 1'b0;
  logic ref_in_use = 1'b1;
  logic cfg_load_done, mem_reset, cfg_load, macro_reset, in_pins_en, luts_en;
  logic seq_cells_en, slow_oscillator_en, fast_oscillator_en, seq_complete;
  logic out_pins_oe, vref_pin_oe, low_power_reference_en, low_power_reference_ready;
  logic [6:0] st;
  int errors = 0;
  int n_checks = 0;
  int dwell [6];
  assign st = {out_pins_oe, seq_complete, seq_cells_en, luts_en, in_pins_en, cfg_load,
               mem_reset};
  always #50 sys_clk = ~sys_clk;
  posq_sequencer posq_sequencer_i (.sys_clk(sys_clk), .nrst(nrst),
    .power_on_threshold(power_on_threshold), .cfg_load_done(cfg_load_done),
    .ref_off_req(ref_off_req), .ref_in_use(ref_in_use), .mem_reset(mem_reset),
    .cfg_load(cfg_load), .macro_reset(macro_reset), .in_pins_en(in_pins_en),
    .luts_en(luts_en), .seq_cells_en(seq_cells_en),
    .slow_oscillator_en(slow_oscillator_en), .fast_oscillator_en(fast_oscillator_en),
    .seq_complete(seq_complete), .out_pins_oe(out_pins_oe), .vref_pin_oe(vref_pin_oe),
    .low_power_reference_en(low_power_reference_en),
    .low_power_reference_ready(low_power_reference_ready));
  posq_mem_model posq_mem_model_i (.sys_clk(sys_clk), .nrst(nrst), .cfg_load(cfg_load),
    .cfg_load_done(cfg_load_done));

  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk_bit(input string what, input logic exp, input logic got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic wait_stage(input int k);
    int n;
    n = 0;
    while (st[k] !== 1'b1 && n < 40) begin
      @(negedge sys_clk);
      n++;
    end
    chk_bit("stage_up", 1'b1, st[k]);
    chk_bit("later_stages_low", 1'b1, (st >> (k + 1)) === 7'h00);
    if (k > 0) chk_bit("dwell", 1'b1, n == dwell[k-1]);
  endtask

  task automatic t_supply_loss();
    power_on_threshold = 1'b1;
    for (int k = 0; k < 4; k++) wait_stage(k);
    power_on_threshold = 1'b0;
    repeat (6) @(negedge sys_clk);
    chk_bit("stages_dropped", 1'b1, st === 7'h00);
    chk_bit("macro_reset", 1'b1, macro_reset);
    chk_bit("osc_off", 1'b0, slow_oscillator_en | fast_oscillator_en);
  endtask

  task automatic t_powerup();
    power_on_threshold = 1'b1;
    chk_bit("macro_reset", 1'b1, macro_reset);
    wait_stage(0);
    chk_bit("out_pins_oe", 1'b0, out_pins_oe);
    wait_stage(1);
    chk_bit("macro_reset", 1'b1, macro_reset);
    wait_stage(2);
    chk_bit("load_released", 1'b0, cfg_load | mem_reset | macro_reset);
    wait_stage(3);
    wait_stage(4);
    chk_bit("slow_oscillator_en", 1'b1, slow_oscillator_en);
    wait_stage(5);
    chk_bit("vref_pin_oe", 1'b1, vref_pin_oe);
    wait_stage(6);
  endtask

  task automatic t_reference();
    int n;
    n = 0;
    while (low_power_reference_ready !== 1'b1 && n < 21000) begin
      @(negedge sys_clk);
      n++;
    end
    chk_bit("reference_ready", 1'b1, low_power_reference_ready);
    // Fast oscillator enable follows the registered ready flag by one cycle
    @(negedge sys_clk);
    chk_bit("fast_oscillator_en", 1'b1, fast_oscillator_en);
    ref_off_req = 1'b1;
    repeat (6) @(negedge sys_clk);
    chk_bit("reference_kept", 1'b1, low_power_reference_en);
    ref_in_use = 1'b0;
    repeat (6) @(negedge sys_clk);
    chk_bit("reference_off", 1'b0, low_power_reference_en);
    chk_bit("fast_oscillator_en", 1'b0, fast_oscillator_en);
    chk_bit("slow_oscillator_en", 1'b1, slow_oscillator_en);
    chk_bit("seq_complete", 1'b1, seq_complete);
    ref_off_req = 1'b0;
    repeat (6) @(negedge sys_clk);
    chk_bit("reference_on", 1'b1, low_power_reference_en);
    chk_bit("not_yet_ready", 1'b0, low_power_reference_ready);
  endtask

  initial begin
    repeat (40000) @(posedge sys_clk);
    errors++;
    $display("watchdog expired");
    wrap_up();
  end

  initial begin
    // Gaps between stage outputs; pins enable at the end of their hold stage
    dwell = '{int'(DWELL_MEM_RESET), int'(DWELL_CFG_LOAD) + int'(DWELL_IN_PINS),
              int'(DWELL_LUTS), int'(DWELL_SEQ_CELLS), int'(DWELL_COMPLETE), 1};
    repeat (5) @(negedge sys_clk);
    chk_bit("reset_macro", 1'b1, macro_reset);
    chk_bit("reset_stages", 1'b1, st === 7'h00);
    nrst = 1'b1;
    repeat (2) @(negedge sys_clk);
    t_supply_loss();
    t_powerup();
    t_reference();
    wrap_up();
  end
endmodule
